// ==== rtl/pci_function_command_control.sv ====
// Command registers of three functions and the bus gating they steer
// How it works
// - Bits 15 to 11 always read zero and ignore writes.
// - Bit 7 always reads zero.
// - A set INTx mask bit keeps that function's INTx deasserted; reset value is zero.
// - The fast back-to-back bit is read-only zero.
// - SERR is only driven when the system error enable is set.
// - An address parity error reaches SERR only with both system error and parity response enabled.
// - Data parity errors assert PERR only with parity response enabled, otherwise they are ignored.
// - With palette snoop set, palette writes are snooped and not claimed; otherwise decoded normally.
// - The write-and-invalidate bit is hardwired zero; only plain memory writes are used.
// - The special-cycle bit is hardwired zero and special cycles are never answered.
// - Bus requests as initiator leave only while the initiator enable is set.
// - Memory-space cycles are claimed only while memory space is enabled.
// - I/O-space cycles are claimed only while I/O space is enabled.
// - Each of the three functions has its own independently written command register.
// - System error and parity response enables read back per function but act as an OR of all three.
// - INTx asserts only with pending status set and mask clear; the mask never alters pending status.
`timescale 1ns/1ps
module pci_function_command_control (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Configuration access
    input wire logic cfg_wr_in,
    input wire logic cfg_rd_in,
    input wire logic [cmd_pkg::FUNC_W-1:0] cfg_func_in,
    input wire logic [cmd_pkg::OFFSET_W-1:0] cfg_offset_in,
    input wire logic [cmd_pkg::BE_W-1:0] cfg_be_in,
    input wire logic [cmd_pkg::CMD_W-1:0] cfg_wdata_in,
    output logic [cmd_pkg::CMD_W-1:0] cfg_rdata_out,
    output logic cfg_rvalid_out,
    // Per-function events and shared parity errors from the bus engine
    input wire logic [cmd_pkg::NUM_FUNC-1:0] int_pending_in,
    input wire logic [cmd_pkg::NUM_FUNC-1:0] initiator_req_in,
    input wire logic [cmd_pkg::NUM_FUNC-1:0] mem_hit_in,
    input wire logic [cmd_pkg::NUM_FUNC-1:0] io_hit_in,
    input wire logic [cmd_pkg::NUM_FUNC-1:0] palette_wr_in,
    input wire logic addr_parity_err_in,
    input wire logic data_parity_err_in,
    // Gated results
    output logic [cmd_pkg::NUM_FUNC-1:0] intx_out,
    output logic [cmd_pkg::NUM_FUNC-1:0] bus_req_out,
    output logic [cmd_pkg::NUM_FUNC-1:0] mem_claim_out,
    output logic [cmd_pkg::NUM_FUNC-1:0] io_claim_out,
    output logic [cmd_pkg::NUM_FUNC-1:0] palette_claim_out,
    output logic [cmd_pkg::NUM_FUNC-1:0] palette_snoop_out,
    // Open-drain error pins, driven low while enabled
    output logic serr_n_out,
    output logic serr_oe_out,
    output logic perr_n_out,
    output logic perr_oe_out
);
    import cmd_pkg::*;

    typedef struct packed {
        logic [CMD_W-1:0] rdata;
        logic rvalid;
        logic [NUM_FUNC-1:0] intx;
        logic [NUM_FUNC-1:0] bus_req;
        logic [NUM_FUNC-1:0] mem_claim;
        logic [NUM_FUNC-1:0] io_claim;
        logic [NUM_FUNC-1:0] pal_claim;
        logic [NUM_FUNC-1:0] pal_snoop;
        logic serr_n;
        logic serr_oe;
        logic perr_n;
        logic perr_oe;
    } ctl_state_t;

    // Command offset decode, shared by the read and write paths
    function automatic logic cmd_hit(input logic [OFFSET_W-1:0] offset);
        cmd_hit = (offset == CMD_OFFSET);
    endfunction

    ctl_state_t state_r;
    ctl_state_t state_nxt;
    logic [CMD_W-1:0] cmd_q [NUM_FUNC];
    logic [NUM_FUNC-1:0] system_error_enable_vec;
    logic [NUM_FUNC-1:0] parity_response_enable_vec;
    logic system_error_enable_any;
    logic parity_response_enable_any;

    cmd_if fn_if [NUM_FUNC] ();

    genvar g;
    generate
        for (g = 0; g < NUM_FUNC; g++) begin : g_func
            // Separate storage per function, nothing shared
            assign fn_if[g].wr = cfg_wr_in && cmd_hit(cfg_offset_in) && cfg_func_in == FUNC_W'(g);
            assign fn_if[g].be = cfg_be_in;
            assign fn_if[g].wdata = cfg_wdata_in;
            assign cmd_q[g] = fn_if[g].cmd;
            assign system_error_enable_vec[g] = fn_if[g].cmd[SYS_ERR_BIT];
            assign parity_response_enable_vec[g] = fn_if[g].cmd[PARITY_RESP_BIT];

            func_cmd_reg u_reg (
                .core_clk_in(core_clk_in),
                .sys_rst_in(sys_rst_in),
                .port(fn_if[g])
            );
        end
    endgenerate

    // Error enables act chip-wide while reading back per function
    assign system_error_enable_any = |system_error_enable_vec;
    assign parity_response_enable_any = |parity_response_enable_vec;

    always_comb begin
        state_nxt = state_r;
        state_nxt.rvalid = cfg_rd_in;
        state_nxt.rdata = '0;
        if (cfg_rd_in && cmd_hit(cfg_offset_in) && cfg_func_in < FUNC_W'(NUM_FUNC)) begin
            state_nxt.rdata = cmd_q[cfg_func_in] & CMD_WRITABLE;
        end
        for (int i = 0; i < NUM_FUNC; i++) begin
            // Mask only gates the pin; pending status is left alone
            state_nxt.intx[i] = int_pending_in[i] && !cmd_q[i][INTX_MASK_BIT];
            state_nxt.bus_req[i] = initiator_req_in[i] && cmd_q[i][INITIATOR_BIT];
            state_nxt.mem_claim[i] = mem_hit_in[i] && cmd_q[i][MEM_SPACE_BIT];
            state_nxt.io_claim[i] = io_hit_in[i] && cmd_q[i][IO_SPACE_BIT];
            state_nxt.pal_claim[i] = palette_wr_in[i] && !cmd_q[i][PALETTE_SNOOP_BIT];
            state_nxt.pal_snoop[i] = palette_wr_in[i] && cmd_q[i][PALETTE_SNOOP_BIT];
        end
        state_nxt.serr_n = 1'b0;
        state_nxt.perr_n = 1'b0;
        state_nxt.serr_oe = addr_parity_err_in && system_error_enable_any && parity_response_enable_any;
        state_nxt.perr_oe = data_parity_err_in && parity_response_enable_any;
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign cfg_rdata_out = state_r.rdata;
    assign cfg_rvalid_out = state_r.rvalid;
    assign intx_out = state_r.intx;
    assign bus_req_out = state_r.bus_req;
    assign mem_claim_out = state_r.mem_claim;
    assign io_claim_out = state_r.io_claim;
    assign palette_claim_out = state_r.pal_claim;
    assign palette_snoop_out = state_r.pal_snoop;
    assign serr_n_out = state_r.serr_n;
    assign serr_oe_out = state_r.serr_oe;
    assign perr_n_out = state_r.perr_n;
    assign perr_oe_out = state_r.perr_oe;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence s_cmd_read;
        cfg_rd_in && cmd_hit(cfg_offset_in) && cfg_func_in < FUNC_W'(NUM_FUNC);
    endsequence

    sequence s_addr_err_enabled;
        addr_parity_err_in && system_error_enable_any && parity_response_enable_any;
    endsequence

    a_cmd_readback: assert property (
        s_cmd_read |=> cfg_rvalid_out && cfg_rdata_out == ($past(cmd_q[cfg_func_in]) & CMD_WRITABLE))
        else $error("command read returned wrong value");

    a_read_reserved: assert property (
        cfg_rvalid_out |-> (cfg_rdata_out & (CMD_RSVD_HI | (CMD_W'(1) << RSVD7_BIT))) == '0)
        else $error("reserved command bits read nonzero");

    a_serr_needs_both: assert property (
        serr_oe_out |-> $past(addr_parity_err_in) && $past(system_error_enable_any) && $past(parity_response_enable_any))
        else $error("SERR driven without both enables");

    a_serr_reports: assert property (
        s_addr_err_enabled |=> serr_oe_out && !serr_n_out)
        else $error("enabled address parity error not reported");

    // A one-edge reset leaves stale enables in the sampled history
    a_perr_gate: assert property (
        !$past(sys_rst_in) |-> perr_oe_out == $past(data_parity_err_in && parity_response_enable_any))
        else $error("PERR drive does not follow enable");

    a_enable_or: assert property (
        (data_parity_err_in && parity_response_enable_vec == 3'h4) |=> perr_oe_out)
        else $error("parity enable of one function not effective");

    a_read_unmapped: assert property (
        (cfg_rd_in && !(cmd_hit(cfg_offset_in) && cfg_func_in < FUNC_W'(NUM_FUNC)))
        |=> cfg_rvalid_out && cfg_rdata_out == '0)
        else $error("unmapped read returned data");

    a_rdata_idle: assert property (
        !cfg_rvalid_out |-> cfg_rdata_out == '0)
        else $error("read data present without valid");

    generate
        for (g = 0; g < NUM_FUNC; g++) begin : g_chk
            a_intx_masked: assert property (
                intx_out[g] |-> $past(int_pending_in[g]) && !$past(cmd_q[g][INTX_MASK_BIT]))
                else $error("INTx asserted while masked or idle");
            a_intx_pending: assert property (
                (int_pending_in[g] && !cmd_q[g][INTX_MASK_BIT]) |=> intx_out[g])
                else $error("INTx missing while pending and unmasked");
            a_initiator_gate: assert property (
                bus_req_out[g] |-> $past(cmd_q[g][INITIATOR_BIT]) && $past(initiator_req_in[g]))
                else $error("bus requested while initiator disabled");
            a_mem_io_gate: assert property (
                ##1 (mem_claim_out[g] == $past(mem_hit_in[g] && cmd_q[g][MEM_SPACE_BIT]))
                && (io_claim_out[g] == $past(io_hit_in[g] && cmd_q[g][IO_SPACE_BIT])))
                else $error("space claim does not follow enable");
            a_palette_snoop: assert property (
                (palette_wr_in[g] && cmd_q[g][PALETTE_SNOOP_BIT]) |=> !palette_claim_out[g] && palette_snoop_out[g])
                else $error("snooped palette write was claimed");
            a_palette_claim: assert property (
                (palette_wr_in[g] && !cmd_q[g][PALETTE_SNOOP_BIT])
                |=> palette_claim_out[g] && !palette_snoop_out[g])
                else $error("unsnooped palette write not claimed");
            a_initiator_req: assert property (
                (initiator_req_in[g] && cmd_q[g][INITIATOR_BIT]) |=> bus_req_out[g])
                else $error("enabled initiator request dropped");
        end
    endgenerate
endmodule

// ==== rtl/cmd_pkg.sv ====
// Shared constants for the per-function command register block
package cmd_pkg;
    localparam int NUM_FUNC = 3;
    localparam int FUNC_W = 2;
    localparam int CMD_W = 16;
    localparam int BE_W = 2;
    localparam int OFFSET_W = 8;
    localparam logic [OFFSET_W-1:0] CMD_OFFSET = 8'h04;
    localparam logic [CMD_W-1:0] CMD_RESET = 16'h0000;
    // Bits software may change: 10, 8, 6, 5, 2, 1, 0
    localparam logic [CMD_W-1:0] CMD_WRITABLE = 16'h0567;
    localparam logic [CMD_W-1:0] CMD_RSVD_HI = 16'hf800;
    localparam int LANE_W = 8;
    localparam int INTX_MASK_BIT = 10;
    localparam int FAST_B2B_BIT = 9;
    localparam int SYS_ERR_BIT = 8;
    localparam int RSVD7_BIT = 7;
    localparam int PARITY_RESP_BIT = 6;
    localparam int PALETTE_SNOOP_BIT = 5;
    localparam int WR_INVAL_BIT = 4;
    localparam int SPECIAL_BIT = 3;
    localparam int INITIATOR_BIT = 2;
    localparam int MEM_SPACE_BIT = 1;
    localparam int IO_SPACE_BIT = 0;
endpackage

// ==== rtl/cmd_if.sv ====
// Carrier between the control logic and one function's command register
`timescale 1ns/1ps
interface cmd_if;
    import cmd_pkg::*;
    logic wr;
    logic [BE_W-1:0] be;
    logic [CMD_W-1:0] wdata;
    logic [CMD_W-1:0] cmd;
    modport ctrl (output wr, output be, output wdata, input cmd);
    modport regs (input wr, input be, input wdata, output cmd);
endinterface

// ==== rtl/func_cmd_reg.sv ====
// One function's command register with byte-lane writes
`timescale 1ns/1ps
module func_cmd_reg (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Register access
    cmd_if.regs port
);
    import cmd_pkg::*;

    typedef struct packed {
        logic [CMD_W-1:0] cmd;
    } reg_state_t;

    reg_state_t state_r;
    reg_state_t state_nxt;
    logic [CMD_W-1:0] wmask;

    always_comb begin
        state_nxt = state_r;
        wmask = {{LANE_W{port.be[1]}}, {LANE_W{port.be[0]}}} & CMD_WRITABLE;
        if (port.wr) begin
            // Fixed and reserved bits never take write data
            state_nxt.cmd = (state_r.cmd & ~wmask) | (port.wdata & wmask);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            state_r <= '{cmd: CMD_RESET};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign port.cmd = state_r.cmd;

    a_fixed_bits_zero: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        (port.cmd & ~CMD_WRITABLE) == '0)
        else $error("fixed command bit reads nonzero");

    a_reset_clears: assert property (@(posedge core_clk_in)
        sys_rst_in |=> port.cmd == CMD_RESET)
        else $error("command register not cleared by reset");

    a_write_lands: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        (port.wr && port.be == 2'h3) |=> port.cmd == ($past(port.wdata) & CMD_WRITABLE))
        else $error("full write not stored");
endmodule

// ==== sim/bus_agent_model.sv ====
// Far-side bus agents that raise per-function events and parity errors
`timescale 1ns/1ps
module bus_agent_model (
    // Stimulus selection
    input wire logic [2:0] events_in,
    input wire logic addr_err_in,
    input wire logic data_err_in,
    // Events seen on the bus
    output logic [2:0] pending_out,
    output logic [2:0] req_out,
    output logic [2:0] mem_hit_out,
    output logic [2:0] io_hit_out,
    output logic [2:0] palette_wr_out,
    output logic addr_perr_out,
    output logic data_perr_out
);
    // Same pattern on every event kind keeps the bench short
    assign pending_out = events_in;
    assign req_out = events_in;
    assign mem_hit_out = events_in;
    assign io_hit_out = events_in;
    assign palette_wr_out = events_in;
    assign addr_perr_out = addr_err_in;
    assign data_perr_out = data_err_in;
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the per-function command registers
`timescale 1ns/1ps
module testbench;
    import cmd_pkg::*;
    logic core_clk_in, sys_rst_in, cfg_wr_in, cfg_rd_in, cfg_rvalid_out;
    logic [FUNC_W-1:0] cfg_func_in;
    logic [OFFSET_W-1:0] cfg_offset_in;
    logic [BE_W-1:0] cfg_be_in;
    logic [CMD_W-1:0] cfg_wdata_in, cfg_rdata_out;
    logic ae, de, perr_a, perr_d, serr_n, serr_oe, perr_n, perr_oe;
    logic [NUM_FUNC-1:0] ev, pend, req, mhit, ihit, pwr, intx, breq, mclm, iclm, pclm, psnp;
    int errors = 0;
    int samples_checked = 0;

    bus_agent_model agent (.events_in(ev), .addr_err_in(ae), .data_err_in(de), .pending_out(pend),
        .req_out(req), .mem_hit_out(mhit), .io_hit_out(ihit), .palette_wr_out(pwr),
        .addr_perr_out(perr_a), .data_perr_out(perr_d));

    pci_function_command_control uut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
        .cfg_wr_in(cfg_wr_in), .cfg_rd_in(cfg_rd_in), .cfg_func_in(cfg_func_in),
        .cfg_offset_in(cfg_offset_in), .cfg_be_in(cfg_be_in), .cfg_wdata_in(cfg_wdata_in),
        .cfg_rdata_out(cfg_rdata_out), .cfg_rvalid_out(cfg_rvalid_out), .int_pending_in(pend),
        .initiator_req_in(req), .mem_hit_in(mhit), .io_hit_in(ihit), .palette_wr_in(pwr),
        .addr_parity_err_in(perr_a), .data_parity_err_in(perr_d), .intx_out(intx),
        .bus_req_out(breq), .mem_claim_out(mclm), .io_claim_out(iclm),
        .palette_claim_out(pclm), .palette_snoop_out(psnp), .serr_n_out(serr_n),
        .serr_oe_out(serr_oe), .perr_n_out(perr_n), .perr_oe_out(perr_oe));

    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    task automatic close_out();
        $display("Checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            errors++;
        end
    endtask

    task automatic cfg_write(input logic [1:0] f, input logic [7:0] off, input logic [1:0] be,
                             input logic [15:0] d);
        cfg_func_in = f;
        cfg_offset_in = off;
        cfg_be_in = be;
        cfg_wdata_in = d;
        cfg_wr_in = 1'b1;
        @(negedge core_clk_in);
        cfg_wr_in = 1'b0;
        @(negedge core_clk_in);
    endtask

    // Answer lasts one cycle, so it is sampled at the very next falling edge
    task automatic cfg_read(input logic [1:0] f, input logic [7:0] off, input logic [15:0] exp);
        cfg_func_in = f;
        cfg_offset_in = off;
        cfg_rd_in = 1'b1;
        @(negedge core_clk_in);
        cfg_rd_in = 1'b0;
        check("rdata", {15'h0000, cfg_rvalid_out, cfg_rdata_out}, {16'h0001, exp});
        @(negedge core_clk_in);
    endtask

    task automatic gate(input logic [2:0] e, input logic a, input logic d, input logic [2:0] xi,
                        input logic [2:0] xb, input logic [2:0] xc, input logic xs, input logic xp);
        ev = e;
        ae = a;
        de = d;
        @(negedge core_clk_in);
        check("gated", {10'h000, intx, breq, mclm, iclm, pclm, psnp, serr_oe, perr_oe, serr_n, perr_n},
              {10'h000, xi, xb, xb, xb, xc, xb, xs, xp, 2'b00});
    endtask

    initial begin
        sys_rst_in = 1'b1;
        {cfg_wr_in, cfg_rd_in, ae, de} = 4'h0;
        cfg_func_in = 2'h0;
        cfg_offset_in = 8'h00;
        cfg_be_in = 2'h0;
        cfg_wdata_in = 16'h0000;
        ev = 3'h0;
        repeat (10) @(negedge core_clk_in);
        sys_rst_in = 1'b0;
        for (int f = 0; f < 3; f++) begin
            cfg_read(f[1:0], 8'h04, 16'h0000);
        end
        $display("Test reset values done");
        cfg_write(2'h1, 8'h04, 2'h3, 16'hffff);
        cfg_read(2'h1, 8'h04, 16'h0567);
        cfg_read(2'h0, 8'h04, 16'h0000);
        cfg_read(2'h2, 8'h04, 16'h0000);
        cfg_write(2'h0, 8'h04, 2'h1, 16'hffff);
        cfg_read(2'h0, 8'h04, 16'h0067);
        cfg_write(2'h0, 8'h04, 2'h2, 16'hffff);
        cfg_read(2'h0, 8'h04, 16'h0567);
        cfg_write(2'h3, 8'h04, 2'h3, 16'hffff);
        cfg_write(2'h2, 8'h08, 2'h3, 16'hffff);
        cfg_read(2'h2, 8'h04, 16'h0000);
        cfg_read(2'h1, 8'h08, 16'h0000);
        $display("Test register access done");
        gate(3'h7, 1'b1, 1'b1, 3'h4, 3'h3, 3'h4, 1'b1, 1'b1);
        gate(3'h0, 1'b0, 1'b0, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0);
        cfg_write(2'h0, 8'h04, 2'h3, 16'h0000);
        cfg_write(2'h1, 8'h04, 2'h3, 16'h0000);
        cfg_write(2'h2, 8'h04, 2'h3, 16'h0100);
        gate(3'h7, 1'b1, 1'b1, 3'h7, 3'h0, 3'h7, 1'b0, 1'b0);
        cfg_write(2'h0, 8'h04, 2'h3, 16'h0040);
        gate(3'h7, 1'b1, 1'b1, 3'h7, 3'h0, 3'h7, 1'b1, 1'b1);
        cfg_write(2'h2, 8'h04, 2'h3, 16'h0000);
        gate(3'h5, 1'b1, 1'b1, 3'h5, 3'h0, 3'h5, 1'b0, 1'b1);
        $display("Test bus gating done");
        // Memory and I/O enables sit in functions 0 and 1, the other set bits in function 2
        cfg_write(2'h0, 8'h04, 2'h3, 16'h0002);
        cfg_write(2'h1, 8'h04, 2'h3, 16'h0001);
        cfg_write(2'h2, 8'h04, 2'h3, 16'h0464);
        ev = 3'h7;
        @(negedge core_clk_in);
        check("split", {12'h000, breq, mclm, iclm, intx, pclm, psnp, serr_oe, perr_oe},
              {12'h000, 3'h4, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 1'b0, 1'b1});
        $display("Test split enables done");
        sys_rst_in = 1'b1;
        @(negedge core_clk_in);
        check("reset outputs", {11'h000, cfg_rvalid_out, intx, breq, mclm, iclm, pclm, psnp, serr_oe, perr_oe},
              32'h0000_0000);
        @(negedge core_clk_in);
        sys_rst_in = 1'b0;
        for (int f = 0; f < 3; f++) begin
            cfg_read(f[1:0], 8'h04, 16'h0000);
        end
        cfg_read(2'h3, 8'h04, 16'h0000);
        check("after reset", {12'h000, intx, breq, mclm, iclm, pclm, psnp, serr_oe, perr_oe},
              {12'h000, 3'h7, 3'h0, 3'h0, 3'h0, 3'h7, 3'h0, 1'b0, 1'b0});
        $display("Test mid-run reset done");
        close_out();
    end

    // Whole sequence needs well under 200 cycles
    initial begin
        repeat (2000) @(posedge core_clk_in);
        errors++;
        close_out();
    end
endmodule
